// File: pkg/link_status_map.svh
// Field positions, reset values, queue thresholds and timing figures of the status block.
// Assumes a 50 ns system clock; included by bare name.
`ifndef LINK_STATUS_MAP_SVH
`define LINK_STATUS_MAP_SVH
// Host status byte field positions
`define SB_RFS_LSB        5
`define SB_IDLE_BIT       4
`define SB_NETWORK_FAULT_FLAG_BIT       3
`define SB_HS_BIT         2
`define SB_TRANSMIT_QUEUE_STATE_LSB       0
`define SB_RESET          8'h10
// Frame completion byte field positions
`define CC_ERR_BIT        7
`define CC_OVR_BIT        6
`define CC_TMS_LSB        4
`define CC_IFR_BIT        3
`define CC_RESPONSE_CRC_FLAG_BIT       2
`define CC_CODE_LSB       0
`define CC_RESET          8'h00
// Queue thresholds
`define RX_LEVEL_13TH     13
`define RX_OVERRUN_BYTES  20
`define TX_LEVEL_ALMOST   10
`define TX_LEVEL_FULL     11
// Timing
`define CLK_PERIOD_NS     50
`define NETWORK_FAULT_FLAG_TIME_NS      60000
`define FILTER_TIME_NS    4000
`define BREAK_TIME_NS     240000
`define NORMAL_DIV        40
`define HS_FACTOR         4
`endif

// File: pkg/link_status_pkg.sv
// Types shared by the status and completion reporting logic.
// Assumes the constants of link_status_map.svh alongside.
package link_status_pkg;
  typedef enum logic [1:0] {
    ERR_CRC        = 2'h0,
    ERR_INCOMPLETE = 2'h1,
    ERR_BIT_TIMING = 2'h2,
    ERR_BREAK      = 2'h3
  } err_code_type;
  typedef enum logic [1:0] {
    TX_NOT_INVOLVED = 2'h0,
    TX_UNDERRUN     = 2'h1,
    TX_LOST         = 2'h2,
    TX_SUCCESS      = 2'h3
  } tx_result_type;
  typedef enum logic [2:0] {
    RFS_EMPTY     = 3'h0,
    RFS_MULTI     = 3'h1,
    RFS_CC_INSIDE = 3'h2,
    RFS_13TH      = 3'h3,
    RFS_ONE       = 3'h4,
    RFS_CC_MORE   = 3'h5,
    RFS_CC_FRAME  = 3'h6,
    RFS_CC_ONLY   = 3'h7
  } rfs_type;
  typedef enum logic {
    FLUSH_IDLE = 1'b0,
    FLUSH_RUN  = 1'b1
  } flush_state_type;
  typedef struct packed {
    logic       is_cc;
    logic [7:0] data;
  } rx_entry_type;
  typedef struct packed {
    logic          err;
    logic          ovr;
    tx_result_type tms;
    logic          ifr;
    logic          response_crc_flag;
    err_code_type  code;
  } frame_flags_type;
  typedef struct packed {
    logic       byte_valid;
    logic [7:0] byte_data;
    logic       byte_start;
    logic       bit_strobe;
    logic       crc_err;
    logic       bit_err;
    logic       eod_timing;
    logic       eod_done;
  } rx_event_type;
  typedef struct packed {
    logic          result_valid;
    tx_result_type result;
    logic          ifr;
    logic          ifr_crc;
    logic          driving;
    logic          abort;
  } tx_event_type;
  typedef struct packed {
    logic spi_mode;
    logic data_read;
    logic flush_byte;
    logic flush_frame;
    logic cmd_busy;
  } host_cmd_type;
  typedef struct packed {
    logic [4:0] count;
    logic       last_loaded;
    logic       block_mode;
  } tx_queue_type;
endpackage : link_status_pkg

// File: verilog/link_status_completion_report.sv
// Status byte, completion code generation and receive queue of the link controller.
// Assumes receiver/transmitter events on clk_sys_i; bus activity and chip select are pins.
`timescale 1ns/10ps
`default_nettype none
`include "link_status_map.svh"

module rx_queue_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic                       clk_sys_i,
  input  wire logic                       arst_n_i,
  // Fill side
  input  wire logic                       in_valid_i,
  input  wire logic [WIDTH-1:0]           in_data_i,
  output logic                            in_ready_o,
  // Drain side
  output logic                            out_valid_o,
  output logic [WIDTH-1:0]                out_data_o,
  input  wire logic                       out_ready_i,
  output logic [$clog2(DEPTH+1)-1:0]      level_o
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("rx_queue_fifo depth must be a power of two of at least 2");
  end
  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic          full;
    logic          empty;
  } fifo_state_type;
  fifo_state_type   s_r;
  fifo_state_type   s_nxt;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             do_wr;
  logic             do_rd;

  assign do_wr       = in_valid_i && !s_r.full;
  assign do_rd       = out_ready_i && !s_r.empty;
  assign in_ready_o  = !s_r.full;
  assign out_valid_o = !s_r.empty;
  assign out_data_o  = mem[s_r.rd_ptr];
  assign level_o     = s_r.count;

  always_comb begin
    s_nxt = s_r;
    if (do_wr) begin
      s_nxt.wr_ptr = s_r.wr_ptr + 1'b1;
    end
    if (do_rd) begin
      s_nxt.rd_ptr = s_r.rd_ptr + 1'b1;
    end
    if (do_wr && !do_rd) begin
      s_nxt.count = s_r.count + 1'b1;
    end else if (do_rd && !do_wr) begin
      s_nxt.count = s_r.count - 1'b1;
    end
    s_nxt.full  = (s_nxt.count == CW'(DEPTH));
    s_nxt.empty = (s_nxt.count == '0);
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_r <= '{wr_ptr: '0, rd_ptr: '0, count: '0, full: 1'b0, empty: 1'b1};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Storage needs no reset; empty flag hides stale words
  always_ff @(posedge clk_sys_i) begin
    if (do_wr) begin
      mem[s_r.wr_ptr] <= in_data_i;
    end
  end
endmodule : rx_queue_fifo

module link_status_completion_report #(
  parameter int DEPTH          = 16,
  parameter int FILTER_TIME_NS = `FILTER_TIME_NS,
  parameter int BREAK_TIME_NS  = `BREAK_TIME_NS,
  parameter int NORMAL_DIV     = `NORMAL_DIV
) (
  // Clock and reset
  input  wire logic                          clk_sys_i,
  input  wire logic                          arst_n_i,
  // Pins
  input  wire logic                          cs_n_i,
  input  wire logic                          bus_active_i,
  // Configuration and controller events
  input  wire logic                          high_speed_select_i,
  input  wire link_status_pkg::rx_event_type rx_event_i,
  input  wire link_status_pkg::tx_event_type tx_event_i,
  input  wire link_status_pkg::host_cmd_type host_cmd_i,
  input  wire link_status_pkg::tx_queue_type tx_queue_i,
  // Host view
  output logic [7:0]                         host_status_byte_o,
  output logic [7:0]                         host_data_byte_o,
  output logic [7:0]                         frame_completion_byte_o,
  // Link side
  output logic                               rx_ready_o,
  output logic                               bus_tick_o,
  output logic                               wave_shape_en_o,
  output logic                               network_fault_flag_o,
  output logic                               ifr_cancel_o
);
  localparam int FILTER_CYC = (FILTER_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int BREAK_CYC  = (BREAK_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int NETWORK_FAULT_FLAG_CYC   = (`NETWORK_FAULT_FLAG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int HS_DIV     = NORMAL_DIV / `HS_FACTOR;
  localparam int CW         = $clog2(DEPTH+1);
  if (FILTER_CYC < 1 || BREAK_CYC <= FILTER_CYC || BREAK_CYC > 65535) begin : g_bad_time
    $error("filter and break times out of range");
  end
  if (HS_DIV < 1 || NORMAL_DIV > 255) begin : g_bad_div
    $error("bus divider out of range");
  end
  if (DEPTH < `RX_LEVEL_13TH) begin : g_bad_depth
    $error("receive queue too shallow for its state codes");
  end

  typedef struct packed {
    logic [2:0]                        act_sync;
    logic                              act;
    logic [2:0]                        cs_sync;
    logic                              cs_act;
    logic [7:0]                        div_cnt;
    logic                              tick;
    logic                              hs;
    logic [15:0]                       act_cnt;
    logic                              idle;
    logic                              activity;
    logic                              break_done;
    logic [15:0]                       network_fault_flag_cnt;
    logic                              network_fault_flag;
    logic [2:0]                        bit_cnt;
    link_status_pkg::frame_flags_type  flags;
    logic                              cc_pend;
    logic [7:0]                        cc_pend_data;
    logic [7:0]                        last_cc;
    logic [CW-1:0]                     cc_count;
    link_status_pkg::flush_state_type  flush;
    logic [7:0]                        status;
    logic [7:0]                        data;
  } state_type;

  state_type                       s_r;
  state_type                       s_nxt;
  logic                            q_in_valid;
  link_status_pkg::rx_entry_type   q_in_data;
  logic                            q_in_ready;
  logic                            q_out_valid;
  link_status_pkg::rx_entry_type   q_out_data;
  logic                            q_pop;
  logic [CW-1:0]                   q_level;

  // Pack flags into the byte by the documented positions
  function automatic logic [7:0] pack_cc(input link_status_pkg::frame_flags_type f);
    logic [7:0] b;
    b = `CC_RESET;
    b[`CC_ERR_BIT]               = f.err;
    b[`CC_OVR_BIT]               = f.ovr;
    b[`CC_TMS_LSB +: 2]          = f.tms;
    b[`CC_IFR_BIT]               = f.ifr;
    b[`CC_RESPONSE_CRC_FLAG_BIT]              = f.response_crc_flag;
    b[`CC_CODE_LSB +: 2]         = f.code;
    return b;
  endfunction : pack_cc

  // Higher code wins; first error of a frame takes its own code
  function automatic link_status_pkg::frame_flags_type raise_err(
    input link_status_pkg::frame_flags_type f,
    input link_status_pkg::err_code_type    c
  );
    link_status_pkg::frame_flags_type r;
    r = f;
    if (!f.err || c > f.code) begin
      r.code = c;
    end
    r.err = 1'b1;
    r.ifr = 1'b0;
    r.response_crc_flag = 1'b0;
    return r;
  endfunction : raise_err

  function automatic link_status_pkg::rfs_type rx_state(
    input logic [CW-1:0] lvl,
    input logic [CW-1:0] ccs,
    input logic          head_cc,
    input logic          flushing
  );
    link_status_pkg::rfs_type r;
    if (lvl == '0 || flushing) begin
      r = link_status_pkg::RFS_EMPTY;
    end else if (head_cc) begin
      if (lvl == CW'(1)) begin
        r = link_status_pkg::RFS_CC_ONLY;
      end else if (ccs > CW'(1)) begin
        r = link_status_pkg::RFS_CC_FRAME;
      end else begin
        r = link_status_pkg::RFS_CC_MORE;
      end
    end else if (ccs != '0) begin
      r = link_status_pkg::RFS_CC_INSIDE;
    end else if (lvl == CW'(1)) begin
      r = link_status_pkg::RFS_ONE;
    end else if (lvl >= CW'(`RX_LEVEL_13TH)) begin
      r = link_status_pkg::RFS_13TH;
    end else begin
      r = link_status_pkg::RFS_MULTI;
    end
    return r;
  endfunction : rx_state

  function automatic logic [1:0] tx_state(input link_status_pkg::tx_queue_type t);
    logic [1:0] r;
    if (t.last_loaded || (t.block_mode && t.count >= 5'(`TX_LEVEL_FULL))) begin
      r = 2'h3;
    end else if (t.count >= 5'(`TX_LEVEL_ALMOST)) begin
      r = 2'h2;
    end else if (t.count != 5'h00) begin
      r = 2'h1;
    end else begin
      r = 2'h0;
    end
    return r;
  endfunction : tx_state

  // Queue pushes: data has priority, a held code waits one slot
  always_comb begin
    q_in_valid = 1'b0;
    q_in_data  = '{is_cc: 1'b0, data: rx_event_i.byte_data};
    if (rx_event_i.byte_valid && !s_r.flags.ovr) begin
      q_in_valid = 1'b1;
    end else if (s_r.cc_pend) begin
      q_in_valid = 1'b1;
      q_in_data  = '{is_cc: 1'b1, data: s_r.cc_pend_data};
    end
  end

  // Queue pops
  always_comb begin
    q_pop = 1'b0;
    if (q_out_valid) begin
      if (s_r.flush == link_status_pkg::FLUSH_RUN) begin
        q_pop = !q_out_data.is_cc;
      end else if (host_cmd_i.flush_byte) begin
        q_pop = 1'b1;
      end else if (!host_cmd_i.spi_mode && host_cmd_i.data_read) begin
        q_pop = !q_out_data.is_cc;
      end
    end
  end

  always_comb begin
    logic          cc_in;
    logic          cc_out;
    logic          close;
    logic [7:0]    status;
    logic [CW-1:0] data_bytes;
    cc_in      = q_in_valid && q_in_ready && q_in_data.is_cc;
    cc_out     = q_pop && q_out_data.is_cc;
    close      = 1'b0;
    data_bytes = q_level - s_r.cc_count;
    s_nxt      = s_r;

    // Pins: third stage confirms the second
    s_nxt.act_sync = {s_r.act_sync[1:0], bus_active_i};
    s_nxt.cs_sync  = {s_r.cs_sync[1:0], !cs_n_i};
    if (s_r.act_sync[2] == s_r.act_sync[1]) begin
      s_nxt.act = s_r.act_sync[2];
    end
    if (s_r.cs_sync[2] == s_r.cs_sync[1]) begin
      s_nxt.cs_act = s_r.cs_sync[2];
    end

    // Bus rate enable
    s_nxt.hs   = high_speed_select_i;
    s_nxt.tick = 1'b0;
    if (s_r.div_cnt == 8'h00) begin
      s_nxt.tick    = 1'b1;
      s_nxt.div_cnt = s_r.hs ? 8'(HS_DIV - 1) : 8'(NORMAL_DIV - 1);
    end else begin
      s_nxt.div_cnt = s_r.div_cnt - 8'h01;
    end

    // Activity filter, idle flag and break detection
    if (s_r.act) begin
      if (s_r.act_cnt != 16'hFFFF) begin
        s_nxt.act_cnt = s_r.act_cnt + 16'h0001;
      end
      if (s_r.act_cnt == 16'(FILTER_CYC - 1)) begin
        s_nxt.idle     = 1'b0;
        s_nxt.activity = 1'b1;
      end
      if (s_r.act_cnt == 16'(BREAK_CYC - 1) && !s_r.flags.ovr && !s_r.break_done) begin
        s_nxt.break_done   = 1'b1;
        s_nxt.cc_pend      = 1'b1;
        s_nxt.cc_pend_data = pack_cc(raise_err(s_r.flags, link_status_pkg::ERR_BREAK));
        close              = 1'b1;
      end
    end else begin
      s_nxt.act_cnt    = 16'h0000;
      s_nxt.break_done = 1'b0;
    end
    if (rx_event_i.eod_timing) begin
      s_nxt.idle = 1'b0;
    end

    // Network fault: driven bus never seen active
    if (tx_event_i.abort) begin
      s_nxt.network_fault_flag = 1'b0;
    end
    if (tx_event_i.driving && !s_r.act && !s_r.network_fault_flag) begin
      s_nxt.network_fault_flag_cnt = s_r.network_fault_flag_cnt + 16'h0001;
      if (s_r.network_fault_flag_cnt == 16'(NETWORK_FAULT_FLAG_CYC - 1)) begin
        s_nxt.network_fault_flag = 1'b1;
      end
    end else begin
      s_nxt.network_fault_flag_cnt = 16'h0000;
    end

    // Frame flag collection
    if (rx_event_i.bit_strobe) begin
      s_nxt.bit_cnt = s_r.bit_cnt + 3'h1;
    end
    if (rx_event_i.crc_err) begin
      s_nxt.flags = raise_err(s_nxt.flags, link_status_pkg::ERR_CRC);
    end
    if (tx_event_i.result_valid && !s_r.flags.ovr) begin
      s_nxt.flags.tms = tx_event_i.result;
    end
    if (tx_event_i.ifr && !s_nxt.flags.err) begin
      s_nxt.flags.ifr  = 1'b1;
      s_nxt.flags.response_crc_flag = tx_event_i.ifr_crc;
    end
    // Bytes past the limit are dropped, earlier ones stay
    if (rx_event_i.byte_start && !s_r.flags.ovr &&
        (data_bytes >= CW'(`RX_OVERRUN_BYTES) || !q_in_ready)) begin
      s_nxt.flags     = raise_err(s_nxt.flags, link_status_pkg::ERR_CRC);
      s_nxt.flags.ovr = 1'b1;
      s_nxt.flags.tms = link_status_pkg::TX_LOST;
    end
    if (rx_event_i.bit_err) begin
      s_nxt.cc_pend      = 1'b1;
      s_nxt.cc_pend_data = pack_cc(raise_err(s_nxt.flags, link_status_pkg::ERR_BIT_TIMING));
      close              = 1'b1;
    end else if (rx_event_i.eod_done) begin
      s_nxt.idle = 1'b1;
      if (s_r.activity) begin
        s_nxt.cc_pend = 1'b1;
        if (s_r.bit_cnt != 3'h0 && !s_r.flags.ovr) begin
          s_nxt.cc_pend_data = pack_cc(raise_err(s_nxt.flags, link_status_pkg::ERR_INCOMPLETE));
        end else begin
          s_nxt.cc_pend_data = pack_cc(s_nxt.flags);
        end
        close = 1'b1;
      end
    end
    if (cc_in && !close) begin
      s_nxt.cc_pend = 1'b0;
      s_nxt.last_cc = q_in_data.data;
    end else if (cc_in) begin
      s_nxt.last_cc = q_in_data.data;
    end
    if (close) begin
      s_nxt.flags    = '{err: 1'b0, ovr: 1'b0, tms: link_status_pkg::TX_NOT_INVOLVED,
                         ifr: 1'b0, response_crc_flag: 1'b0, code: link_status_pkg::ERR_CRC};
      s_nxt.activity = 1'b0;
      s_nxt.bit_cnt  = 3'h0;
    end

    // Completion code bookkeeping
    if (cc_in && !cc_out) begin
      s_nxt.cc_count = s_r.cc_count + 1'b1;
    end else if (cc_out && !cc_in) begin
      s_nxt.cc_count = s_r.cc_count - 1'b1;
    end

    // Frame flush cycles the queue up to a completion code
    unique case (s_r.flush)
      link_status_pkg::FLUSH_IDLE: begin
        if (host_cmd_i.flush_frame && !(q_out_valid && q_out_data.is_cc)) begin
          s_nxt.flush = link_status_pkg::FLUSH_RUN;
        end
      end
      link_status_pkg::FLUSH_RUN: begin
        if (q_out_valid && q_out_data.is_cc) begin
          s_nxt.flush = link_status_pkg::FLUSH_IDLE;
        end
      end
    endcase

    // Host snapshot; frozen under chip select or a running command
    status = `SB_RESET;
    status[`SB_RFS_LSB +: 3] = rx_state(q_level, s_r.cc_count, q_out_data.is_cc,
                                        s_r.flush == link_status_pkg::FLUSH_RUN);
    status[`SB_IDLE_BIT]     = s_r.idle;
    status[`SB_NETWORK_FAULT_FLAG_BIT]     = s_r.network_fault_flag;
    status[`SB_HS_BIT]       = s_r.hs;
    status[`SB_TRANSMIT_QUEUE_STATE_LSB +: 2] = tx_state(tx_queue_i);
    if (!s_r.cs_act && !host_cmd_i.cmd_busy) begin
      s_nxt.status = status;
      s_nxt.data   = q_out_valid ? q_out_data.data : 8'h00;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_r <= '{act_sync: 3'h0, act: 1'b0, cs_sync: 3'h0, cs_act: 1'b0, div_cnt: 8'h00,
               tick: 1'b0, hs: 1'b0, act_cnt: 16'h0000, idle: 1'b1, activity: 1'b0,
               break_done: 1'b0, network_fault_flag_cnt: 16'h0000, network_fault_flag: 1'b0, bit_cnt: 3'h0,
               flags: `CC_RESET, cc_pend: 1'b0, cc_pend_data: `CC_RESET,
               last_cc: `CC_RESET, cc_count: '0, flush: link_status_pkg::FLUSH_IDLE,
               status: `SB_RESET, data: 8'h00};
    end else begin
      s_r <= s_nxt;
    end
  end

  rx_queue_fifo #(
    .WIDTH (9),
    .DEPTH (DEPTH)
  ) u_rx_queue (
    .clk_sys_i   (clk_sys_i),
    .arst_n_i    (arst_n_i),
    .in_valid_i  (q_in_valid),
    .in_data_i   (q_in_data),
    .in_ready_o  (q_in_ready),
    .out_valid_o (q_out_valid),
    .out_data_o  (q_out_data),
    .out_ready_i (q_pop),
    .level_o     (q_level)
  );

  assign host_status_byte_o      = s_r.status;
  assign host_data_byte_o        = s_r.data;
  assign frame_completion_byte_o = s_r.last_cc;
  assign rx_ready_o              = q_in_ready;
  assign bus_tick_o              = s_r.tick;
  assign wave_shape_en_o         = !s_r.hs;
  assign network_fault_flag_o    = s_r.network_fault_flag;
  assign ifr_cancel_o            = s_r.flags.err;
endmodule : link_status_completion_report
`default_nettype wire

// File: tb/link_status_sva.sv
// Checker of the status and completion reporting block, bound to its top module.
// Assumes one clock domain and the active-low asynchronous reset.
`timescale 1ns/10ps
`default_nettype none
module link_status_sva (
  // Clock and reset
  input wire logic                          clk_sys_i,
  input wire logic                          arst_n_i,
  // Inputs watched
  input wire logic                          cs_n_i,
  input wire logic                          high_speed_select_i,
  input wire link_status_pkg::tx_event_type tx_event_i,
  input wire link_status_pkg::host_cmd_type host_cmd_i,
  // Outputs watched
  input wire logic [7:0]                    host_status_byte_o,
  input wire logic [7:0]                    host_data_byte_o,
  input wire logic [7:0]                    frame_completion_byte_o,
  input wire logic                          bus_tick_o,
  input wire logic                          wave_shape_en_o,
  input wire logic                          network_fault_flag_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  a_wave_shape_off: assert property (wave_shape_en_o != $past(high_speed_select_i))
    else $error("shaping does not follow speed");
  // Five samples cover the three-flop select synchroniser
  a_status_frozen: assert property ((!cs_n_i) [*5] |=> $stable(host_status_byte_o)
    && $stable(host_data_byte_o)) else $error("status moved under select");
  a_tick_gap: assert property (bus_tick_o |=> (!bus_tick_o) [*8])
    else $error("bus ticks too close");
  a_hs_shown: assert property ((cs_n_i && !host_cmd_i.cmd_busy && $stable(high_speed_select_i))
    [*6] |-> host_status_byte_o[2] == high_speed_select_i) else $error("speed bit wrong");
  a_fault_held: assert property (network_fault_flag_o && !tx_event_i.abort |=>
    network_fault_flag_o) else $error("fault flag dropped");
  a_fault_cause: assert property ($rose(network_fault_flag_o) |-> $past(tx_event_i.driving))
    else $error("fault without driving");
  a_err_no_resp: assert property ($changed(frame_completion_byte_o) && frame_completion_byte_o[7]
    |-> !frame_completion_byte_o[3]) else $error("response kept on error");
  a_overrun_fields: assert property (frame_completion_byte_o[6] |->
    frame_completion_byte_o[7:4] == 4'hE) else $error("overrun fields wrong");
  c_fault: cover property ($rose(network_fault_flag_o));
  c_overrun: cover property ($rose(frame_completion_byte_o[6]));
  c_fast_tick: cover property (bus_tick_o && !wave_shape_en_o);
endmodule : link_status_sva
bind link_status_completion_report link_status_sva sva (
  .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .cs_n_i(cs_n_i),
  .high_speed_select_i(high_speed_select_i), .tx_event_i(tx_event_i),
  .host_cmd_i(host_cmd_i), .host_status_byte_o(host_status_byte_o),
  .host_data_byte_o(host_data_byte_o), .frame_completion_byte_o(frame_completion_byte_o),
  .bus_tick_o(bus_tick_o), .wave_shape_en_o(wave_shape_en_o),
  .network_fault_flag_o(network_fault_flag_o));
`default_nettype wire

// File: tb/host_model.sv
// Host side model: chip select and receive queue commands.
// Assumes its tasks are called from one process of the bench.
`timescale 1ns/10ps
`default_nettype none
module host_model (
  // Clock
  input wire logic                      clk_sys_i,
  // Device view
  input wire logic [7:0]                status_i,
  input wire logic [7:0]                data_i,
  // To device
  output logic                          cs_n_o,
  output link_status_pkg::host_cmd_type cmd_o
);
  initial begin
    cs_n_o = 1'b1;
    cmd_o = '0;
  end
  // Status and data taken as one pair under select
  task rd(output logic [7:0] s, output logic [7:0] d);
    @(posedge clk_sys_i) cs_n_o <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    s = status_i;
    d = data_i;
    cs_n_o <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
  endtask : rd
  // Pulse commands; interface mode and busy stay levels
  task cmd(input logic [4:0] v);
    @(posedge clk_sys_i) cmd_o <= v;
    @(posedge clk_sys_i) cmd_o <= v & 5'h11;
    repeat (2) @(posedge clk_sys_i);
  endtask : cmd
endmodule : host_model
`default_nettype wire

// File: tb/link_status_completion_report_tb.sv
// Self-checking bench of the status and completion reporting block.
// Assumes the host model drives select and commands; filter and break times scaled down, network fault time not.
`timescale 1ns/10ps
`default_nettype none
module link_status_completion_report_tb;
  logic clk_sys_i, arst_n_i, bus_active_i, hs, cs_n, ws, nf, rr, ic;
  link_status_pkg::rx_event_type rx;
  link_status_pkg::tx_event_type tx;
  link_status_pkg::host_cmd_type cmd;
  link_status_pkg::tx_queue_type txq;
  logic [7:0] sb, db, cb, s, d, v;
  logic [31:0] seed;
  int n_mismatch, n_tests, cyc, i;
  link_status_completion_report #(.FILTER_TIME_NS(200), .BREAK_TIME_NS(2000)) dut (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .cs_n_i(cs_n), .bus_active_i(bus_active_i),
    .high_speed_select_i(hs), .rx_event_i(rx), .tx_event_i(tx), .host_cmd_i(cmd),
    .tx_queue_i(txq), .host_status_byte_o(sb), .host_data_byte_o(db),
    .frame_completion_byte_o(cb), .rx_ready_o(rr), .bus_tick_o(), .wave_shape_en_o(ws),
    .network_fault_flag_o(nf), .ifr_cancel_o(ic));
  host_model host (.clk_sys_i(clk_sys_i), .status_i(sb), .data_i(db), .cs_n_o(cs_n),
    .cmd_o(cmd));
  function logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  function logic [7:0] ccx(input logic [1:0] t, input logic [1:0] c);
    return {2'b10, t, 2'b00, c};
  endfunction : ccx
  function logic [7:0] tfs(input link_status_pkg::tx_queue_type q);
    if (q.last_loaded || (q.count == 5'd11 && q.block_mode)) return 8'h03;
    if (q.count == 5'd10) return 8'h02;
    return (q.count == 5'd0) ? 8'h00 : 8'h01;
  endfunction : tfs
  task chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk
  // Bits of one byte; a short count leaves it incomplete
  task byt(input logic [7:0] b, input int nb);
    @(posedge clk_sys_i) bus_active_i <= 1'b1;
    for (int k = 0; k < nb; k++) begin
      @(posedge clk_sys_i);
      rx.byte_start <= (k == 0);
      rx.bit_strobe <= 1'b1;
      rx.byte_valid <= (k == 7);
      rx.byte_data <= b;
    end
    @(posedge clk_sys_i) {rx, bus_active_i} <= '0;
    @(posedge clk_sys_i);
  endtask : byt
  task ev(input int k);
    @(posedge clk_sys_i) rx[k] <= 1'b1;
    @(posedge clk_sys_i) rx <= '0;
  endtask : ev
  task rd;
    repeat (3) @(posedge clk_sys_i);
    host.rd(s, d);
  endtask : rd
  task print_verdict;
    $display("mismatches %0d tests %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict
  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  // Whole run is a few thousand cycles
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      n_mismatch++;
      print_verdict;
    end
  end
  initial begin
    {arst_n_i, bus_active_i, hs, cyc, n_mismatch, n_tests} = '0;
    {rx, tx, txq} = '0;
    seed = 32'h66D0ADF2;
    repeat (8) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    rd;
    chk(s, 8'h10);
    chk(cb, 8'h00);
    v = rnd();
    byt(v, 8);
    rd;
    chk(s >> 5, 8'h04);
    byt(rnd(), 8);
    rd;
    chk(s >> 5, 8'h01);
    ev(0);
    rd;
    chk(s >> 5, 8'h02);
    chk(cb, 8'h00);
    host.cmd(5'h18);
    rd;
    chk(d, v);
    host.cmd(5'h08);
    rd;
    chk(s >> 5, 8'h02);
    host.cmd(5'h08);
    rd;
    chk(d, 8'h00);
    host.cmd(5'h08);
    rd;
    chk(s >> 5, 8'h07);
    host.cmd(5'h04);
    rd;
    chk(s >> 5, 8'h00);
    for (i = 0; i < 4; i++) begin
      byt(rnd(), 4 + i);
      @(posedge clk_sys_i) tx <= {1'b1, 2'(i), 4'hC};
      @(posedge clk_sys_i) tx <= '0;
      ev(0);
      rd;
      chk(d, ccx(2'(i), 2'h1));
      host.cmd(5'h04);
    end
    ev(3);
    @(posedge clk_sys_i);
    chk(8'(ic), 8'h01);
    ev(2);
    rd;
    chk(cb, ccx(2'h0, 2'h2));
    host.cmd(5'h04);
    for (i = 0; i < 17; i++) begin
      byt(rnd(), 8);
      if (i == 16) chk(8'(rr), 8'h00);
      if (i == 12) begin
        rd;
        chk(s >> 5, 8'h03);
      end
    end
    host.cmd(5'h08);
    ev(0);
    host.cmd(5'h02);
    repeat (20) @(posedge clk_sys_i);
    rd;
    chk(d, 8'hE0);
    chk(s >> 5, 8'h07);
    host.cmd(5'h04);
    host.cmd(5'h01);
    byt(rnd(), 8);
    rd;
    chk(s >> 5, 8'h00);
    host.cmd(5'h00);
    rd;
    chk(s >> 5, 8'h04);
    host.cmd(5'h04);
    @(posedge clk_sys_i) hs <= 1'b1;
    for (i = 0; i < 6; i++) begin
      @(posedge clk_sys_i);
      txq.count <= 5'(i == 1 ? 10 : i == 2 ? 11 : i == 3 ? 0 : rnd() % 10);
      txq.block_mode <= 1'b1;
      txq.last_loaded <= (i == 5);
      rd;
      chk(s & 8'h07, 8'h04 | tfs(txq));
    end
    chk(8'(ws), 8'h00);
    @(posedge clk_sys_i) bus_active_i <= 1'b1;
    repeat (12) @(posedge clk_sys_i);
    bus_active_i <= 1'b0;
    rd;
    chk(s & 8'h10, 8'h00);
    @(posedge clk_sys_i) tx <= 7'h0C;
    ev(0);
    rd;
    chk(s & 8'h10, 8'h10);
    chk(s >> 5, 8'h07);
    chk(d, 8'h0C);
    ev(1);
    rd;
    chk(s & 8'h10, 8'h00);
    @(posedge clk_sys_i) tx <= 7'h02;
    repeat (1300) @(posedge clk_sys_i);
    chk(8'(nf), 8'h01);
    tx <= 7'h01;
    @(posedge clk_sys_i) tx <= '0;
    repeat (3) @(posedge clk_sys_i);
    chk(8'(nf), 8'h00);
    print_verdict;
  end
endmodule : link_status_completion_report_tb
`default_nettype wire
